/* logic/ucsp_top.sv */
// Operation
// - map bit moves scratch ram to code space
// - bit five enables pin zero blinking while pin zero is an output
// - blink one second period, half duty
// - bit four puts write strobe on pin4
// - bit three picks timer one trigger source
// - bit two picks timer zero trigger source
// - bit one puts serial transmit on pin1
// - bit zero feeds or grounds serial receive
// - data window write stores at pointer
// - data window read returns byte at pointer
// - low pointer holds address bits seven to zero
// - high pointer holds three bits, rest zero
// - pointer steps after every window access
`timescale 1ns/1ns
`default_nettype none
module ucsp_top
    import ucsp_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYCLES = BLINK_HALF_CYC
)
(
    input  wire logic              SYS_CLK_I,
    input  wire logic              RSTN_I,
    input  wire logic              CE_I,
    // avalon-mm slave
    input  wire logic [BUS_AW-1:0] AVS_ADDRESS_I,
    input  wire logic              AVS_READ_I,
    input  wire logic              AVS_WRITE_I,
    input  wire logic [3:0]        AVS_BYTEENABLE_I,
    input  wire logic [BUS_DW-1:0] AVS_WRITEDATA_I,
    output logic      [BUS_DW-1:0] AVS_READDATA_O,
    output logic                   AVS_WAITREQUEST_O,
    // mcu memory decode
    input  wire logic [15:0]       MCU_ADDR_I,
    input  wire logic              MCU_CODE_SPACE_I,
    output logic                   SCRATCH_RAM_CODE_MAP_O,
    output logic                   SCRATCH_SEL_O,
    // general purpose pin sources
    input  wire logic [4:0]        GPIO_OUT_VAL_I,
    input  wire logic              GPIO0_DIR_OUT_I,
    input  wire logic [3:0]        PIN_IN_I,
    output logic      [4:0]        PIN_OUT_O,
    // mcu side signals
    input  wire logic              PORT3_LINE1_SERIAL_TX_I,
    input  wire logic              DRIVE_IO_WRITE_STROBE_N_I,
    output logic                   PORT3_LINE0_SERIAL_RX_O,
    output logic                   PORT3_LINE4_TIMER0_IN_O,
    output logic                   PORT3_LINE5_TIMER1_IN_O
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    ucsp_bus_state_t  st_q;
    ucsp_bus_state_t  st_d;
    logic [7:0]       util_q;
    logic [7:0]       util_d;
    logic [PTR_W-1:0] ptr_q;
    logic [PTR_W-1:0] ptr_d;
    logic [7:0]       mem_q [RAM_DEPTH];
    logic [7:0]       mem_d [RAM_DEPTH];
    logic [7:0]       rdata_q;
    logic [7:0]       rdata_d;
    logic [3:0]       sync1_q;
    logic [3:0]       sync2_q;
    logic [3:0]       sync3_q;
    logic [3:0]       pin_q;
    logic [3:0]       pin_d;
    logic [4:0]       pout_q;
    logic [4:0]       pout_d;
    logic [2:0]       tmr_rx_q;
    logic [2:0]       tmr_rx_d;
    logic             sel_q;
    logic             sel_d;
    logic             req;
    logic             commit;
    logic             wr_ok;
    logic             blink_run;
    logic             blink_wave;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [BUS_AW-1:0] a, input logic [7:0] idx);
        hit = (a[BUS_AW-1:2] == idx) && (a[1:0] == WORD_LANE_ZERO);
    endfunction

    function automatic logic in_scratch(input logic [15:0] a);
        in_scratch = (a >= SCRATCH_LO) && (a <= SCRATCH_HI);
    endfunction

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    // one wait cycle per access; frozen while clock enable is low
    assign req               = AVS_READ_I | AVS_WRITE_I;
    assign commit            = req && (st_q == UCSP_ST_ACK) && CE_I;
    assign wr_ok             = commit && AVS_WRITE_I && AVS_BYTEENABLE_I[0];
    assign AVS_WAITREQUEST_O = req && !commit;

    // answer state
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            UCSP_ST_IDLE:
            begin
                if (req)
                begin
                    st_d = UCSP_ST_ACK;
                end
            end
            UCSP_ST_ACK:
            begin
                st_d = UCSP_ST_IDLE;
            end
            default:
            begin
                st_d = UCSP_ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // read data capture
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_d = rdata_q;
        if (AVS_READ_I && (st_q == UCSP_ST_IDLE))
        begin
            if (hit(AVS_ADDRESS_I, IDX_UTIL_CFG))
            begin
                rdata_d = util_q;
            end
            else if (hit(AVS_ADDRESS_I, IDX_DATA_WIN))
            begin
                rdata_d = mem_q[ptr_q];
            end
            else if (hit(AVS_ADDRESS_I, IDX_PTR_LOW))
            begin
                rdata_d = ptr_q[7:0];
            end
            else if (hit(AVS_ADDRESS_I, IDX_PTR_HIGH))
            begin
                rdata_d = {5'h00, ptr_q[PTR_W-1:8]};
            end
            else
            begin
                rdata_d = 8'h00; // unmapped reads zero
            end
        end
    end

    assign AVS_READDATA_O = {24'h000000, rdata_q};

    // ------------------------------------------------------------
    // configuration and pointer registers
    // ------------------------------------------------------------
    always_comb
    begin
        util_d = util_q;
        ptr_d  = ptr_q;
        if (wr_ok && hit(AVS_ADDRESS_I, IDX_UTIL_CFG))
        begin
            util_d = AVS_WRITEDATA_I[7:0];
        end
        else if (wr_ok && hit(AVS_ADDRESS_I, IDX_PTR_LOW))
        begin
            ptr_d[7:0] = AVS_WRITEDATA_I[7:0];
        end
        else if (wr_ok && hit(AVS_ADDRESS_I, IDX_PTR_HIGH))
        begin
            ptr_d[PTR_W-1:8] = AVS_WRITEDATA_I[PTR_HIGH_W-1:0];
        end
        else if (commit && hit(AVS_ADDRESS_I, IDX_DATA_WIN))
        begin
            ptr_d = ptr_q + PTR_STEP;
        end
    end

    // ------------------------------------------------------------
    // buffer ram
    // ------------------------------------------------------------
    always_comb
    begin
        mem_d = mem_q;
        if (wr_ok && hit(AVS_ADDRESS_I, IDX_DATA_WIN))
        begin
            mem_d[ptr_q] = AVS_WRITEDATA_I[7:0];
        end
    end

    // ------------------------------------------------------------
    // pin input filter
    // ------------------------------------------------------------
    // change accepted once second and third stages agree
    always_comb
    begin
        pin_d = pin_q;
        for (int i = 0; i < 4; i++)
        begin
            if (sync2_q[i] == sync3_q[i])
            begin
                pin_d[i] = sync3_q[i];
            end
        end
    end

    // ------------------------------------------------------------
    // pin multiplexing
    // ------------------------------------------------------------
    assign blink_run = util_q[BIT_BLINK_EN] && GPIO0_DIR_OUT_I;

    always_comb
    begin
        pout_d = GPIO_OUT_VAL_I;
        if (blink_run)
        begin
            pout_d[0] = blink_wave;
        end
        if (util_q[BIT_P1_TX])
        begin
            pout_d[1] = PORT3_LINE1_SERIAL_TX_I;
        end
        if (util_q[BIT_P4_STROBE])
        begin
            pout_d[4] = DRIVE_IO_WRITE_STROBE_N_I;
        end
        // timer0, timer1, serial receive
        tmr_rx_d[0] = util_q[BIT_T0_SRC] ? 1'b0 : pin_q[2];
        tmr_rx_d[1] = util_q[BIT_T1_SRC] ? 1'b0 : pin_q[3];
        tmr_rx_d[2] = util_q[BIT_RX_SRC] ? 1'b0 : pin_q[0];
    end

    assign PIN_OUT_O               = pout_q;
    assign PORT3_LINE4_TIMER0_IN_O = tmr_rx_q[0];
    assign PORT3_LINE5_TIMER1_IN_O = tmr_rx_q[1];
    assign PORT3_LINE0_SERIAL_RX_O = tmr_rx_q[2];

    // ------------------------------------------------------------
    // scratch ram decode
    // ------------------------------------------------------------
    // selects scratch ram only in the space the map bit names
    always_comb
    begin
        sel_d = in_scratch(MCU_ADDR_I) && (MCU_CODE_SPACE_I == util_q[BIT_CODE_MAP]);
    end

    assign SCRATCH_RAM_CODE_MAP_O = util_q[BIT_CODE_MAP];
    assign SCRATCH_SEL_O          = sel_q;

    // ------------------------------------------------------------
    // blink generator
    // ------------------------------------------------------------
    ucsp_blink #(
        .HALF_CYCLES (BLINK_HALF_CYCLES)
    ) u_blink (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RSTN_I),
        .ce_i    (CE_I),
        .run_i   (blink_run),
        .wave_o  (blink_wave)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // control, bus and pin state
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            st_q     <= UCSP_ST_IDLE;
            util_q   <= UTIL_CFG_RST;
            ptr_q    <= PTR_RST;
            rdata_q  <= DATA_WIN_RST;
            sync1_q  <= 4'h0;
            sync2_q  <= 4'h0;
            sync3_q  <= 4'h0;
            pin_q    <= 4'h0;
            pout_q   <= 5'h00;
            tmr_rx_q <= 3'h0;
            sel_q    <= 1'b0;
        end
        else if (CE_I)
        begin
            st_q     <= st_d;
            util_q   <= util_d;
            ptr_q    <= ptr_d;
            rdata_q  <= rdata_d;
            sync1_q  <= PIN_IN_I;
            sync2_q  <= sync1_q;
            sync3_q  <= sync2_q;
            pin_q    <= pin_d;
            pout_q   <= pout_d;
            tmr_rx_q <= tmr_rx_d;
            sel_q    <= sel_d;
        end
    end

    // buffer ram storage
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            for (int i = 0; i < RAM_DEPTH; i++)
            begin
                mem_q[i] <= DATA_WIN_RST;
            end
        end
        else if (CE_I)
        begin
            mem_q <= mem_d;
        end
    end

endmodule
`default_nettype wire

/* pkg/ucsp_pkg.sv */
`default_nettype none
package ucsp_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int unsigned   BUS_AW          = 10;
    localparam int unsigned   BUS_DW          = 32;
    localparam logic [1:0]    WORD_LANE_ZERO  = 2'h0;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0]    IDX_UTIL_CFG    = 8'h9d;
    localparam logic [7:0]    IDX_DATA_WIN    = 8'h9f;
    localparam logic [7:0]    IDX_PTR_LOW     = 8'ha1;
    localparam logic [7:0]    IDX_PTR_HIGH    = 8'ha2;

    // ------------------------------------------------------------
    // utility configuration fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned   BIT_CODE_MAP    = 7;
    localparam int unsigned   BIT_RESERVED    = 6;
    localparam int unsigned   BIT_BLINK_EN    = 5;
    localparam int unsigned   BIT_P4_STROBE   = 4;
    localparam int unsigned   BIT_T1_SRC      = 3;
    localparam int unsigned   BIT_T0_SRC      = 2;
    localparam int unsigned   BIT_P1_TX       = 1;
    localparam int unsigned   BIT_RX_SRC      = 0;
    localparam logic [7:0]    UTIL_CFG_RST    = 8'h00;
    localparam logic [7:0]    DATA_WIN_RST    = 8'h00;

    // ------------------------------------------------------------
    // buffer ram pointer and storage
    // ------------------------------------------------------------
    localparam int unsigned   PTR_W           = 11;
    localparam int unsigned   PTR_HIGH_W      = 3;
    localparam int unsigned   RAM_DEPTH       = 2048;
    localparam logic [10:0]   PTR_RST         = 11'h000;
    localparam logic [10:0]   PTR_STEP        = 11'h001;

    // ------------------------------------------------------------
    // scratch ram window in mcu space
    // ------------------------------------------------------------
    localparam logic [15:0]   SCRATCH_LO      = 16'h0400;
    localparam logic [15:0]   SCRATCH_HI      = 16'h06ff;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned   CLK_PERIOD_NS   = 10;
    localparam int unsigned   BLINK_PERIOD_NS = 1000000000;
    localparam int unsigned   BLINK_HALF_CYC  = BLINK_PERIOD_NS / CLK_PERIOD_NS / 2;
    localparam int unsigned   BLINK_CNT_W     = 26;

    // ------------------------------------------------------------
    // bus answer state
    // ------------------------------------------------------------
    typedef enum logic [0:0]
    {
        UCSP_ST_IDLE = 1'b0,
        UCSP_ST_ACK  = 1'b1
    } ucsp_bus_state_t;

endpackage
`default_nettype wire

/* logic/ucsp_blink.sv */
`timescale 1ns/1ns
`default_nettype none
module ucsp_blink
    import ucsp_pkg::*;
#(
    parameter int unsigned HALF_CYCLES = BLINK_HALF_CYC
)
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic run_i,
    output logic      wave_o
);

    logic [BLINK_CNT_W-1:0] cnt_q;
    logic [BLINK_CNT_W-1:0] cnt_d;
    logic                   wave_q;
    logic                   wave_d;

    localparam logic [BLINK_CNT_W-1:0] LAST = BLINK_CNT_W'(HALF_CYCLES - 1);

    // ------------------------------------------------------------
    // half period counter, restarts low when stopped
    // ------------------------------------------------------------
    always_comb
    begin
        cnt_d  = cnt_q;
        wave_d = wave_q;
        if (!run_i)
        begin
            cnt_d  = '0;
            wave_d = 1'b0;
        end
        else if (cnt_q == LAST)
        begin
            cnt_d  = '0;
            wave_d = ~wave_q; // equal high and low halves
        end
        else
        begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    // registers
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q  <= '0;
            wave_q <= 1'b0;
        end
        else if (ce_i)
        begin
            cnt_q  <= cnt_d;
            wave_q <= wave_d;
        end
    end

    assign wave_o = wave_q;

endmodule
`default_nettype wire

/* verification/ucsp_top_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module ucsp_top_sva
    import ucsp_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYCLES = BLINK_HALF_CYC
)
(
    input wire logic              SYS_CLK_I,
    input wire logic              RSTN_I,
    input wire logic              CE_I,
    input wire logic [BUS_AW-1:0] AVS_ADDRESS_I,
    input wire logic              AVS_READ_I,
    input wire logic              AVS_WRITE_I,
    input wire logic [3:0]        AVS_BYTEENABLE_I,
    input wire logic [BUS_DW-1:0] AVS_WRITEDATA_I,
    input wire logic [BUS_DW-1:0] AVS_READDATA_O,
    input wire logic              AVS_WAITREQUEST_O,
    input wire logic [15:0]       MCU_ADDR_I,
    input wire logic              MCU_CODE_SPACE_I,
    input wire logic              SCRATCH_RAM_CODE_MAP_O,
    input wire logic              SCRATCH_SEL_O,
    input wire logic [4:0]        GPIO_OUT_VAL_I,
    input wire logic [4:0]        PIN_OUT_O,
    input wire logic              PORT3_LINE1_SERIAL_TX_I,
    input wire logic              DRIVE_IO_WRITE_STROBE_N_I,
    input wire logic              PORT3_LINE0_SERIAL_RX_O
);
    // ------------------------------------------------------------
    // config mirror and expected pin sources
    // ------------------------------------------------------------
    logic [7:0] cfg_q;
    logic       cfg_wr, sel_exp, p1_exp, p4_exp;
    assign cfg_wr  = AVS_WRITE_I && !AVS_WAITREQUEST_O && CE_I && AVS_BYTEENABLE_I[0]
                     && (AVS_ADDRESS_I == {IDX_UTIL_CFG, 2'h0});
    assign sel_exp = (MCU_ADDR_I >= SCRATCH_LO) && (MCU_ADDR_I <= SCRATCH_HI)
                     && (MCU_CODE_SPACE_I == SCRATCH_RAM_CODE_MAP_O);
    assign p1_exp  = cfg_q[BIT_P1_TX] ? PORT3_LINE1_SERIAL_TX_I : GPIO_OUT_VAL_I[1];
    assign p4_exp  = cfg_q[BIT_P4_STROBE] ? DRIVE_IO_WRITE_STROBE_N_I : GPIO_OUT_VAL_I[4];

    // mirror of the configuration register
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
            cfg_q <= UTIL_CFG_RST;
        else if (cfg_wr)
            cfg_q <= AVS_WRITEDATA_I[7:0];
    end

    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RSTN_I);

    sequence s_taken;
        (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O && CE_I;
    endsequence

    a_one_wait_cycle: assert property (s_taken |=> !AVS_WAITREQUEST_O)
        else $error("request not answered after one wait cycle");
    a_rdata_upper_zero: assert property (AVS_READDATA_O[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_map_bit_write: assert property (cfg_wr |=> SCRATCH_RAM_CODE_MAP_O == $past(AVS_WRITEDATA_I[7]))
        else $error("code map bit does not follow write");
    a_scratch_decode: assert property ($past(RSTN_I) && $past(CE_I) |-> SCRATCH_SEL_O == $past(sel_exp))
        else $error("scratch select decode wrong");
    a_pin1_tx_mux: assert property ($past(RSTN_I) && $past(CE_I) |-> PIN_OUT_O[1] == $past(p1_exp))
        else $error("pin1 source wrong");
    a_pin4_strobe_mux: assert property ($past(RSTN_I) && $past(CE_I) |-> PIN_OUT_O[4] == $past(p4_exp))
        else $error("pin4 source wrong");
    a_rx_held_low: assert property ($past(cfg_q[BIT_RX_SRC]) && $past(CE_I) |-> !PORT3_LINE0_SERIAL_RX_O)
        else $error("serial receive not grounded");
    a_high_ptr_zero: assert property (AVS_READ_I && !AVS_WAITREQUEST_O
        && AVS_ADDRESS_I == {IDX_PTR_HIGH, 2'h0} |-> AVS_READDATA_O[7:3] == 5'h0)
        else $error("high pointer reserved bits not zero");
endmodule
`default_nettype wire

/* verification/ucsp_mcu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ucsp_mcu_model
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    output logic      tx_o,
    output logic      strobe_n_o
);
    logic [3:0] cnt_q;

    // free running pattern behind serial transmit and write strobe
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_q <= 4'h0;
        else
            cnt_q <= cnt_q + 4'h1;
    end
    assign tx_o       = cnt_q[1] ^ cnt_q[3];
    assign strobe_n_o = (cnt_q[2:0] != 3'h5); // low one cycle in eight
endmodule
`default_nettype wire

/* verification/test_utility_config_and_sram_port.sv */
`timescale 1ns/1ns
`default_nettype none
module test_utility_config_and_sram_port
    import ucsp_pkg::*;
;
    logic              SYS_CLK_I = 1'b0;
    logic              RSTN_I, CE_I, AVS_READ_I, AVS_WRITE_I, MCU_CODE_SPACE_I, GPIO0_DIR_OUT_I, prv;
    logic [BUS_AW-1:0] AVS_ADDRESS_I;
    logic [3:0]        AVS_BYTEENABLE_I, PIN_IN_I;
    logic [BUS_DW-1:0] AVS_WRITEDATA_I, AVS_READDATA_O;
    logic              AVS_WAITREQUEST_O, SCRATCH_RAM_CODE_MAP_O, SCRATCH_SEL_O, tx, strobe_n;
    logic              PORT3_LINE0_SERIAL_RX_O, PORT3_LINE4_TIMER0_IN_O, PORT3_LINE5_TIMER1_IN_O;
    logic [15:0]       MCU_ADDR_I;
    logic [4:0]        GPIO_OUT_VAL_I, PIN_OUT_O;
    int                err_total = 0, n_checks = 0, cyc = 0, hi = 0, tog = 0;

    // ------------------------------------------------------------
    // clock, partner, design and bus tasks
    // ------------------------------------------------------------
    always #5 SYS_CLK_I = ~SYS_CLK_I;

    ucsp_mcu_model u_mcu (.clk_i(SYS_CLK_I), .rst_n_i(RSTN_I), .tx_o(tx), .strobe_n_o(strobe_n));

    ucsp_top #(.BLINK_HALF_CYCLES(8)) dut (.SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .CE_I(CE_I),
        .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
        .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
        .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
        .MCU_ADDR_I(MCU_ADDR_I), .MCU_CODE_SPACE_I(MCU_CODE_SPACE_I),
        .SCRATCH_RAM_CODE_MAP_O(SCRATCH_RAM_CODE_MAP_O), .SCRATCH_SEL_O(SCRATCH_SEL_O),
        .GPIO_OUT_VAL_I(GPIO_OUT_VAL_I), .GPIO0_DIR_OUT_I(GPIO0_DIR_OUT_I), .PIN_IN_I(PIN_IN_I),
        .PIN_OUT_O(PIN_OUT_O), .PORT3_LINE1_SERIAL_TX_I(tx), .DRIVE_IO_WRITE_STROBE_N_I(strobe_n),
        .PORT3_LINE0_SERIAL_RX_O(PORT3_LINE0_SERIAL_RX_O), .PORT3_LINE4_TIMER0_IN_O(PORT3_LINE4_TIMER0_IN_O),
        .PORT3_LINE5_TIMER1_IN_O(PORT3_LINE5_TIMER1_IN_O));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one avalon access, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
        @(posedge SYS_CLK_I);
        AVS_ADDRESS_I   <= {idx, 2'h0};
        AVS_WRITEDATA_I <= {24'h0, d};
        AVS_WRITE_I     <= w;
        AVS_READ_I      <= !w;
        @(posedge SYS_CLK_I);
        while (AVS_WAITREQUEST_O !== 1'b0)
            @(posedge SYS_CLK_I);
        q = AVS_READDATA_O[7:0];
        AVS_WRITE_I <= 1'b0;
        AVS_READ_I  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(q, exp);
    endtask

    task automatic sel(input logic [15:0] a, input logic sp, input logic e);
        @(posedge SYS_CLK_I);
        MCU_ADDR_I       <= a;
        MCU_CODE_SPACE_I <= sp;
        repeat (2) @(negedge SYS_CLK_I);
        chk(8'(SCRATCH_SEL_O), 8'(e));
    endtask

    // hang guard
    always @(posedge SYS_CLK_I)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        {RSTN_I, AVS_READ_I, AVS_WRITE_I, MCU_CODE_SPACE_I, GPIO0_DIR_OUT_I} = 5'h00;
        {CE_I, AVS_BYTEENABLE_I, PIN_IN_I, AVS_ADDRESS_I} = 19'h44000; // enabled, byte lane zero on
        {AVS_WRITEDATA_I, MCU_ADDR_I, GPIO_OUT_VAL_I} = 53'h0;
        repeat (3) @(posedge SYS_CLK_I);
        RSTN_I <= 1'b1;
        rd(IDX_UTIL_CFG, UTIL_CFG_RST);
        rd(IDX_PTR_LOW, 8'h00);
        rd(IDX_PTR_HIGH, 8'h00);
        rd(IDX_DATA_WIN, DATA_WIN_RST);
        rd(IDX_PTR_LOW, 8'h01);
        rd(8'h9e, 8'h00);
        // pointer at top, then two writes across the wrap
        wr(IDX_PTR_LOW, 8'hff);
        wr(IDX_PTR_HIGH, 8'hff);
        rd(IDX_PTR_HIGH, 8'h07);
        wr(IDX_DATA_WIN, 8'ha5);
        wr(IDX_DATA_WIN, 8'h5a);
        rd(IDX_PTR_LOW, 8'h01);
        rd(IDX_PTR_HIGH, 8'h00);
        wr(IDX_PTR_LOW, 8'hff);
        wr(IDX_PTR_HIGH, 8'h07);
        rd(IDX_DATA_WIN, 8'ha5);
        rd(IDX_DATA_WIN, 8'h5a);
        // carry from low into high
        wr(IDX_PTR_LOW, 8'hff);
        wr(IDX_PTR_HIGH, 8'h00);
        wr(IDX_DATA_WIN, 8'h3c);
        rd(IDX_PTR_HIGH, 8'h01);
        rd(IDX_PTR_LOW, 8'h00);
        // scratch ram decode in both spaces, bit 6 kept clear
        wr(IDX_UTIL_CFG, 8'h80);
        rd(IDX_UTIL_CFG, 8'h80);
        // write with byte lane zero disabled is answered but ignored
        @(posedge SYS_CLK_I);
        AVS_BYTEENABLE_I <= 4'h0;
        wr(IDX_UTIL_CFG, 8'h00);
        @(posedge SYS_CLK_I);
        AVS_BYTEENABLE_I <= 4'h1;
        rd(IDX_UTIL_CFG, 8'h80);
        sel(16'h0400, 1'b1, 1'b1);
        sel(16'h06ff, 1'b1, 1'b1);
        sel(16'h0700, 1'b1, 1'b0);
        sel(16'h0400, 1'b0, 1'b0);
        wr(IDX_UTIL_CFG, 8'h00);
        sel(16'h0400, 1'b0, 1'b1);
        sel(16'h03ff, 1'b0, 1'b0);
        // input routing, then forced low
        @(posedge SYS_CLK_I);
        PIN_IN_I <= 4'hd;
        repeat (8) @(negedge SYS_CLK_I);
        chk(8'(PORT3_LINE0_SERIAL_RX_O), 8'h01);
        chk(8'(PORT3_LINE4_TIMER0_IN_O), 8'h01);
        chk(8'(PORT3_LINE5_TIMER1_IN_O), 8'h01);
        wr(IDX_UTIL_CFG, 8'h0d);
        repeat (3) @(negedge SYS_CLK_I);
        chk(8'(PORT3_LINE0_SERIAL_RX_O), 8'h00);
        chk(8'(PORT3_LINE4_TIMER0_IN_O), 8'h00);
        chk(8'(PORT3_LINE5_TIMER1_IN_O), 8'h00);
        // output muxes on pins 1 and 4 switched on, pins 2 and 3 checked to keep their values
        @(posedge SYS_CLK_I);
        GPIO_OUT_VAL_I <= 5'h15;
        wr(IDX_UTIL_CFG, 8'h12);
        repeat (20) @(negedge SYS_CLK_I);
        chk(8'(PIN_OUT_O[3:2]), 8'h01);
        // blink on pin0, then normal output again
        @(posedge SYS_CLK_I);
        GPIO0_DIR_OUT_I <= 1'b1;
        wr(IDX_UTIL_CFG, 8'h20);
        repeat (4) @(negedge SYS_CLK_I);
        prv = PIN_OUT_O[0];
        for (int i = 0; i < 64; i++)
        begin
            @(negedge SYS_CLK_I);
            hi += int'(PIN_OUT_O[0]);
            tog += int'(PIN_OUT_O[0] !== prv);
            prv = PIN_OUT_O[0];
        end
        chk(8'(hi), 8'h20);
        chk(8'(tog), 8'h08);
        // clock enable low freezes the blink for a full half period
        @(posedge SYS_CLK_I);
        CE_I <= 1'b0;
        @(negedge SYS_CLK_I);
        prv = PIN_OUT_O[0];
        repeat (8) @(negedge SYS_CLK_I);
        chk(8'(PIN_OUT_O[0]), 8'(prv));
        @(posedge SYS_CLK_I);
        CE_I <= 1'b1;
        wr(IDX_UTIL_CFG, 8'h00);
        repeat (3) @(negedge SYS_CLK_I);
        chk(8'(PIN_OUT_O[0]), 8'h01);
        // no blink while pin0 is an input
        @(posedge SYS_CLK_I);
        GPIO0_DIR_OUT_I <= 1'b0;
        wr(IDX_UTIL_CFG, 8'h20);
        repeat (20) @(negedge SYS_CLK_I);
        chk(8'(PIN_OUT_O[0]), 8'h01);
        // reset in mid run clears the pointer
        @(posedge SYS_CLK_I);
        RSTN_I <= 1'b0;
        repeat (3) @(posedge SYS_CLK_I);
        RSTN_I <= 1'b1;
        rd(IDX_PTR_HIGH, 8'h00);
        test_done();
    end
endmodule

bind ucsp_top ucsp_top_sva #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) u_sva (.SYS_CLK_I(SYS_CLK_I),
    .RSTN_I(RSTN_I), .CE_I(CE_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
    .AVS_WRITE_I(AVS_WRITE_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .MCU_ADDR_I(MCU_ADDR_I),
    .MCU_CODE_SPACE_I(MCU_CODE_SPACE_I), .SCRATCH_RAM_CODE_MAP_O(SCRATCH_RAM_CODE_MAP_O),
    .SCRATCH_SEL_O(SCRATCH_SEL_O), .GPIO_OUT_VAL_I(GPIO_OUT_VAL_I), .PIN_OUT_O(PIN_OUT_O),
    .PORT3_LINE1_SERIAL_TX_I(PORT3_LINE1_SERIAL_TX_I), .DRIVE_IO_WRITE_STROBE_N_I(DRIVE_IO_WRITE_STROBE_N_I),
    .PORT3_LINE0_SERIAL_RX_O(PORT3_LINE0_SERIAL_RX_O));
`default_nettype wire
